// [test/ccx_exec_assertions.sv]
/*
 * Port assertions for the clear, complement and compare execution block.
 * Assumes a bind from the testbench top file and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module ccx_exec_assertions (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        wdtClearPulse,
    input wire logic        busyOut
);
    // ****************************************************************
    // Clocking and the steps of an instruction run
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_start; $rose(busyOut); endsequence
    sequence s_oneCycle; busyOut[*4]; endsequence
    sequence s_firstAccess; psel && !penable ##1 psel && penable; endsequence

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_ready_wait: assert property (s_firstAccess |-> !pready)
        else $error("pready without wait state");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_wdt_pulse: assert property (wdtClearPulse |-> busyOut ##1 !wdtClearPulse)
        else $error("watchdog clear pulse malformed");
    a_busy_quarters: assert property (s_start |-> s_oneCycle)
        else $error("instruction shorter than four quarters");
    a_busy_bound: assert property (s_start |-> ##[4:12] !busyOut)
        else $error("instruction longer than three cycles");
endmodule
`default_nettype wire

// [test/ccx_wdt_model.sv]
/*
 * Behavioural external watchdog counter and clear-strobe counter.
 * Assumes the clear pulse is a one-cycle strobe in the system clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module ccx_wdt_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        wdtClearPulse,
    output var  logic [15:0] wdtCount_ff,
    output var  logic [7:0]  clearCount_ff
);
    // Counter runs free and restarts from zero on each clear strobe.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wdtCount_ff   <= 16'h0000;
            clearCount_ff <= 8'h00;
        end else if (wdtClearPulse) begin
            wdtCount_ff   <= 16'h0000;
            clearCount_ff <= clearCount_ff + 8'h01;
        end else begin
            wdtCount_ff <= wdtCount_ff + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// [test/tb_clear_complement_compare_exec.sv]
/*
 * Self-checking testbench of the execution block over APB.
 * Assumes the register map header and the watchdog model file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ccx_regs.vh"
module tb_clear_complement_compare_exec;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, wdtClearPulse, busyOut;
    logic [11:0] paddr, ad, idx;
    logic [31:0] pwdata, prdata;
    logic [15:0] wdtCount;
    logic [7:0]  clears, v, f, b, r;
    logic [64:0] q[$];
    integer mismatches, samples_checked, seed, cycles, k;

    ccx_exec u_ccx_exec (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wdtClearPulse(wdtClearPulse), .busyOut(busyOut));
    ccx_wdt_model u_ccx_wdt_model (.clk_sys(clk_sys), .rst_n(rst_n),
        .wdtClearPulse(wdtClearPulse), .wdtCount_ff(wdtCount), .clearCount_ff(clears));

    // ****************************************************************
    // Checking, bus tasks and closing report
    // ****************************************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Pready is taken at a rising edge; only the hang limit ends a stuck wait.
        do @(posedge clk_sys); while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        q.push_back({32'h0, 1'b0, 32'h0});
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] d);
        q.push_back({m, 1'b0, d});
        apb(1'b0, a, 32'h0);
    endtask
    task mem(input logic [11:0] a, input logic [7:0] d);
        wr(`CCX_ADDR_DADDR, {20'h0, a});
        wr(`CCX_ADDR_DDATA, {24'h0, d});
    endtask
    task chk(input logic [11:0] a, input logic [7:0] d);
        wr(`CCX_ADDR_DADDR, {20'h0, a});
        rd(`CCX_ADDR_DDATA, 32'hff, {24'h0, d});
    endtask
    // Reading the working register stalls until the instruction is over.
    task run(input logic [31:0] i);
        wr(`CCX_ADDR_INSTR, i);
        rd(`CCX_ADDR_WREG, 32'h0, 32'h0);
    endtask

    // Monitor takes the oldest note at each completed transfer.
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1) begin
            if (q.size() == 0) check(32'h1, 32'h0);
            else begin
                check({31'h0, pslverr}, {31'h0, q[0][32]});
                check(prdata & q[0][64:33], q[0][31:0] & q[0][64:33]);
                void'(q.pop_front());
            end
        end
    end
    // Clock and hang limit.
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles > 20000) begin
            mismatches = mismatches + 1;
            test_done;
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0; mismatches = 0; samples_checked = 0; seed = 86; cycles = 0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        // Reset values and unmapped places.
        rd(`CCX_ADDR_CTRL, 32'hffffffff, 32'h0);
        rd(`CCX_ADDR_BANK, 32'hffffffff, 32'h0);
        rd(`CCX_ADDR_WREG, 32'hffffffff, 32'h0);
        rd(`CCX_ADDR_IDXBASE, 32'hffffffff, 32'h0);
        rd(`CCX_ADDR_STATUS, 32'h0f, 32'h0c);
        q.push_back({32'h0, 1'b1, 32'h0});
        apb(1'b1, 12'h028, 32'h1);
        q.push_back({32'hffffffff, 1'b1, 32'h0});
        apb(1'b0, 12'h02c, 32'h0);
        // Clear in a selected bank, at the top of the low access half, above it.
        for (k = 0; k < 3; k = k + 1) begin
            b = $random(seed); v = $random(seed) | 8'h01; f = $random(seed);
            if (k == 1) f = `CCX_IDX_LIMIT;
            if (k == 2) f = `CCX_ACCESS_SPLIT;
            ad = (k == 0) ? {b[3:0], f} : {(k == 2) ? 4'hf : 4'h0, f};
            wr(`CCX_ADDR_BANK, {28'h0, b[3:0]});
            mem(ad, v);
            wr(`CCX_ADDR_STATUS, 32'h0);
            run({16'h0, `CCX_OP_CLR_HI, k == 0, f});
            chk(ad, 8'h00);
            rd(`CCX_ADDR_STATUS, 32'h0f, 32'h01);
            rd(`CCX_ADDR_CYCLES, 32'h3, 32'h1);
        end
        // Complement through indexed offset, to memory and to the working register.
        wr(`CCX_ADDR_CTRL, 32'h1);
        for (k = 0; k < 2; k = k + 1) begin
            idx = $random(seed); v = $random(seed); f = $unsigned($random(seed)) % 96;
            ad = idx + {4'h0, f}; r = ~v;
            wr(`CCX_ADDR_IDXBASE, {20'h0, idx});
            wr(`CCX_ADDR_WREG, 32'h5a);
            mem(ad, v);
            wr(`CCX_ADDR_STATUS, 32'h0);
            run({16'h0, `CCX_OP_COMPLEMENT_REGISTER_OP_HI, k[0], 1'b0, f});
            chk(ad, k ? r : v);
            rd(`CCX_ADDR_WREG, 32'hff, k ? 32'h5a : {24'h0, r});
            rd(`CCX_ADDR_STATUS, 32'h3, {30'h0, r[7], r == 8'h00});
        end
        // Compare: unequal, equal, equal before a two-word instruction.
        wr(`CCX_ADDR_CTRL, 32'h0);
        for (k = 0; k < 3; k = k + 1) begin
            b = $random(seed); v = $random(seed); f = $random(seed);
            ad = {b[3:0], f};
            wr(`CCX_ADDR_BANK, {28'h0, b[3:0]});
            mem(ad, v);
            wr(`CCX_ADDR_WREG, {24'h0, (k == 0) ? ~v : v});
            wr(`CCX_ADDR_STATUS, 32'h0b);
            run({15'h0, k == 2, `CCX_OP_CPEQ_HI, 1'b1, f});
            rd(`CCX_ADDR_STATUS, 32'h2f, {26'h0, k != 0, 5'h0b});
            rd(`CCX_ADDR_CYCLES, 32'h3, 32'h1 + (k != 0) + (k == 2));
            chk(ad, v);
        end
        // Watchdog clear, then a neighbouring word that must not clear it.
        wr(`CCX_ADDR_STATUS, 32'h0);
        run({16'h0, `CCX_OP_WDTCLR});
        rd(`CCX_ADDR_STATUS, 32'h4c, 32'h0c);
        rd(`CCX_ADDR_WDTCNT, 32'hff, 32'h1);
        check({24'h0, clears}, 32'h1);
        check({31'h0, wdtCount < 16'd200}, 32'h1);
        wr(`CCX_ADDR_STATUS, 32'h0);
        run(32'h5);
        rd(`CCX_ADDR_STATUS, 32'h4c, 32'h40);
        rd(`CCX_ADDR_CYCLES, 32'h3, 32'h1);
        check({24'h0, clears}, 32'h1);
        repeat (4) @(posedge clk_sys);
        test_done;
    end
endmodule

bind ccx_exec ccx_exec_assertions u_ccx_exec_assertions (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdtClearPulse(wdtClearPulse),
    .busyOut(busyOut));
`default_nettype wire

// [verilog/ccx_addr_resolve.v]
/*
 * Operand address resolution for register-operand instructions.
 * Assumes a purely combinational use by the execution core, with the bank
 * select value, extended-mode enable and index base held stable meanwhile.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ccx_regs.vh"

module ccx_addr_resolve (
    input  wire        accessBit,
    input  wire [7:0]  fileAddr,
    input  wire [3:0]  bankSelect,
    input  wire        extEnable,
    input  wire [11:0] idxBase,
    output reg  [11:0] dataAddr,
    output reg         idxMode
);

    // ****************************************************************
    // Bank selection
    // ****************************************************************

    // Picks access bank, banked general purpose space or indexed offset.
    always @* begin
        idxMode = 1'b0;
        if (accessBit) begin
            dataAddr = {bankSelect, fileAddr};
        end else if (extEnable && (fileAddr <= `CCX_IDX_LIMIT)) begin
            idxMode  = 1'b1;
            dataAddr = idxBase + {4'h0, fileAddr};
        end else if (fileAddr < `CCX_ACCESS_SPLIT) begin
            dataAddr = {`CCX_ACCESS_LO_BANK, fileAddr};
        end else begin
            dataAddr = {`CCX_ACCESS_HI_BANK, fileAddr};
        end
    end

endmodule
`default_nettype wire

// [verilog/ccx_exec.v]
/*
 * Execution core for clear-register, watchdog clear, complement and
 * compare-equal-skip instructions, with its own data memory and an APB
 * slave through which software loads instructions and inspects state.
 * Assumes one 250 MHz clock, an APB master in the same clock domain and an
 * external watchdog that restarts on the one-cycle clear pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ccx_regs.vh"

module ccx_exec (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         wdtClearPulse,
    output reg         busyOut
);

    // ****************************************************************
    // State encodings
    // ****************************************************************
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_EXEC = 2'h1;
    localparam [1:0] ST_NOP1 = 2'h2;
    localparam [1:0] ST_NOP2 = 2'h3;

    // ****************************************************************
    // Storage
    // ****************************************************************
    reg  [7:0]  dataMem [0:4095];
    reg  [1:0]  state_ff;
    reg  [1:0]  qPhase_ff;
    reg  [15:0] instr_ff;
    reg         twoWordNext_ff;
    reg         extEnable_ff;
    reg  [3:0]  bankSelect_ff;
    reg  [7:0]  wreg_ff;
    reg         zeroFlag_ff;
    reg         negFlag_ff;
    reg         pdFlagN_ff;
    reg         toFlagN_ff;
    reg         skipFlag_ff;
    reg         illegal_ff;
    reg  [11:0] idxBase_ff;
    reg  [11:0] swAddr_ff;
    reg  [1:0]  cycles_ff;
    reg  [7:0]  wdtClears_ff;
    reg  [7:0]  operand_ff;
    reg  [7:0]  result_ff;
    reg         resultToW_ff;
    reg         doWrite_ff;
    reg         skip_ff;
    reg  [11:0] opAddr_ff;
    reg         startReq_ff;

    wire [11:0] resolvedAddr;
    wire        isClr;
    wire        isComf;
    wire        isCpeq;
    wire        isWdt;
    wire        apbAccess;
    wire        apbStall;
    wire        apbDone;
    wire        swWrite;

    // ****************************************************************
    // Decode helpers
    // ****************************************************************

    // Returns one when the address names a mapped register.
    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `CCX_ADDR_CTRL) || (a == `CCX_ADDR_BANK) ||
                     (a == `CCX_ADDR_WREG) || (a == `CCX_ADDR_STATUS) ||
                     (a == `CCX_ADDR_INSTR) || (a == `CCX_ADDR_DADDR) ||
                     (a == `CCX_ADDR_DDATA) || (a == `CCX_ADDR_IDXBASE) ||
                     (a == `CCX_ADDR_CYCLES) || (a == `CCX_ADDR_WDTCNT);
        end
    endfunction

    // Opcode classification of the held instruction word.
    assign isClr  = (instr_ff[15:9] == `CCX_OP_CLR_HI);
    assign isComf = (instr_ff[15:10] == `CCX_OP_COMPLEMENT_REGISTER_OP_HI);
    assign isCpeq = (instr_ff[15:9] == `CCX_OP_CPEQ_HI);
    assign isWdt  = (instr_ff == `CCX_OP_WDTCLR);

    // Operand address from access bit, operand byte and bank state.
    ccx_addr_resolve uAddr (
        .accessBit  (instr_ff[8]),
        .fileAddr   (instr_ff[7:0]),
        .bankSelect (bankSelect_ff),
        .extEnable  (extEnable_ff),
        .idxBase    (idxBase_ff),
        .dataAddr   (resolvedAddr),
        .idxMode    ()
    );

    // ****************************************************************
    // APB handshake
    // ****************************************************************

    // While an instruction runs only status and cycle reads pass, so
    // software can never race the core for memory or working register.
    assign apbAccess = psel && penable && !pready;
    assign apbStall  = (state_ff != ST_IDLE || startReq_ff) &&
                       !(!pwrite && (paddr == `CCX_ADDR_STATUS ||
                                     paddr == `CCX_ADDR_CYCLES));
    assign apbDone   = apbAccess && !apbStall;
    assign swWrite   = psel && penable && pready && pwrite && mapped(paddr); // Lands at the completing edge.

    // Registered ready, read data and error answer.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apbDone;
            pslverr <= apbDone && !mapped(paddr);
            if (apbDone && !pwrite) begin
                case (paddr)
                    `CCX_ADDR_CTRL:    prdata <= {31'h0, extEnable_ff};
                    `CCX_ADDR_BANK:    prdata <= {28'h0, bankSelect_ff};
                    `CCX_ADDR_WREG:    prdata <= {24'h0, wreg_ff};
                    `CCX_ADDR_STATUS:  prdata <= {25'h0, illegal_ff, skipFlag_ff,
                                                  busyOut, toFlagN_ff, pdFlagN_ff,
                                                  negFlag_ff, zeroFlag_ff};
                    `CCX_ADDR_INSTR:   prdata <= {15'h0, twoWordNext_ff, instr_ff};
                    `CCX_ADDR_DADDR:   prdata <= {20'h0, swAddr_ff};
                    `CCX_ADDR_DDATA:   prdata <= {24'h0, dataMem[swAddr_ff]};
                    `CCX_ADDR_IDXBASE: prdata <= {20'h0, idxBase_ff};
                    `CCX_ADDR_CYCLES:  prdata <= {30'h0, cycles_ff};
                    `CCX_ADDR_WDTCNT:  prdata <= {24'h0, wdtClears_ff};
                    default:           prdata <= 32'h0000_0000;
                endcase
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ****************************************************************
    // Software-written configuration
    // ****************************************************************

    // Control, bank, index base and memory pointer registers.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            extEnable_ff   <= 1'b0;
            bankSelect_ff  <= `CCX_RST_BANK;
            idxBase_ff     <= `CCX_RST_IDXBASE;
            swAddr_ff      <= 12'h000;
            instr_ff       <= 16'h0000;
            twoWordNext_ff <= 1'b0;
            startReq_ff    <= 1'b0;
        end else begin
            startReq_ff <= 1'b0;
            if (swWrite) begin
                case (paddr)
                    `CCX_ADDR_CTRL:    extEnable_ff  <= pwdata[`CCX_CTRL_EXT];
                    `CCX_ADDR_BANK:    bankSelect_ff <= pwdata[3:0];
                    `CCX_ADDR_IDXBASE: idxBase_ff    <= pwdata[11:0];
                    `CCX_ADDR_DADDR:   swAddr_ff     <= pwdata[11:0];
                    `CCX_ADDR_INSTR: begin
                        instr_ff       <= pwdata[15:0];
                        twoWordNext_ff <= pwdata[`CCX_INSTR_TWOWORD];
                        startReq_ff    <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end

    // ****************************************************************
    // Quarter-cycle sequencer
    // ****************************************************************

    // Four clock edges make one instruction cycle; the phase runs only
    // while an instruction or its no-op cycles are in progress.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= ST_IDLE;
            qPhase_ff <= `CCX_Q1;
            cycles_ff <= 2'h0;
            busyOut   <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    qPhase_ff <= `CCX_Q1;
                    if (startReq_ff) begin
                        state_ff  <= ST_EXEC;
                        cycles_ff <= `CCX_CYC_ONE;
                        busyOut   <= 1'b1;
                    end
                end
                ST_EXEC: begin
                    qPhase_ff <= qPhase_ff + 2'h1;
                    if (qPhase_ff == `CCX_Q4) begin
                        if (skip_ff) begin
                            state_ff  <= ST_NOP1;
                            cycles_ff <= cycles_ff + 2'h1;
                        end else begin
                            state_ff <= ST_IDLE;
                            busyOut  <= 1'b0;
                        end
                    end
                end
                ST_NOP1: begin
                    qPhase_ff <= qPhase_ff + 2'h1;
                    if (qPhase_ff == `CCX_Q4) begin
                        if (twoWordNext_ff) begin
                            state_ff  <= ST_NOP2;
                            cycles_ff <= cycles_ff + 2'h1;
                        end else begin
                            state_ff <= ST_IDLE;
                            busyOut  <= 1'b0;
                        end
                    end
                end
                ST_NOP2: begin
                    qPhase_ff <= qPhase_ff + 2'h1;
                    if (qPhase_ff == `CCX_Q4) begin
                        state_ff <= ST_IDLE;
                        busyOut  <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                    busyOut  <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Datapath per quarter
    // ****************************************************************

    // Q1 decodes and latches the address, Q2 reads the operand, Q3
    // computes the result and flags, Q4 writes the destination.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            opAddr_ff     <= 12'h000;
            operand_ff    <= 8'h00;
            result_ff     <= 8'h00;
            resultToW_ff  <= 1'b0;
            doWrite_ff    <= 1'b0;
            skip_ff       <= 1'b0;
            skipFlag_ff   <= 1'b0;
            illegal_ff    <= 1'b0;
            wreg_ff       <= `CCX_RST_WREG;
            zeroFlag_ff   <= `CCX_RST_ZERO;
            negFlag_ff    <= `CCX_RST_NEG;
            pdFlagN_ff    <= `CCX_RST_PD_N;
            toFlagN_ff    <= `CCX_RST_TO_N;
            wdtClearPulse <= 1'b0;
            wdtClears_ff  <= 8'h00;
        end else begin
            wdtClearPulse <= 1'b0;
            if (swWrite && paddr == `CCX_ADDR_WREG) begin
                wreg_ff <= pwdata[7:0];
            end
            if (swWrite && paddr == `CCX_ADDR_STATUS) begin
                zeroFlag_ff <= pwdata[`CCX_ST_ZERO];
                negFlag_ff  <= pwdata[`CCX_ST_NEG];
                pdFlagN_ff  <= pwdata[`CCX_ST_PD_N];
                toFlagN_ff  <= pwdata[`CCX_ST_TO_N];
            end
            if (state_ff == ST_EXEC) begin
                case (qPhase_ff)
                    `CCX_Q1: begin
                        opAddr_ff   <= resolvedAddr;
                        skip_ff     <= 1'b0;
                        doWrite_ff  <= 1'b0;
                        skipFlag_ff <= 1'b0;
                        illegal_ff  <= !(isClr || isComf || isCpeq || isWdt);
                    end
                    `CCX_Q2: begin
                        operand_ff <= dataMem[opAddr_ff];
                    end
                    `CCX_Q3: begin
                        if (isClr) begin
                            result_ff    <= `CCX_CLEAR_VALUE;
                            resultToW_ff <= 1'b0;
                            doWrite_ff   <= 1'b1;
                            zeroFlag_ff  <= 1'b1;
                        end else if (isComf) begin
                            result_ff    <= ~operand_ff;
                            resultToW_ff <= !instr_ff[9];
                            doWrite_ff   <= 1'b1;
                            negFlag_ff   <= ~operand_ff[7];
                            zeroFlag_ff  <= (operand_ff == 8'hff);
                        end else if (isCpeq) begin
                            skip_ff     <= (operand_ff == wreg_ff);
                            skipFlag_ff <= (operand_ff == wreg_ff);
                        end else if (isWdt) begin
                            wdtClearPulse <= 1'b1;
                            wdtClears_ff  <= wdtClears_ff + 8'h01;
                            toFlagN_ff    <= 1'b1;
                            pdFlagN_ff    <= 1'b1;
                        end
                    end
                    `CCX_Q4: begin
                        if (doWrite_ff && resultToW_ff) begin
                            wreg_ff <= result_ff;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ****************************************************************
    // Data memory
    // ****************************************************************

    // Core writes land in Q4; software writes only reach it while idle.
    always @(posedge clk_sys) begin
        if (state_ff == ST_EXEC && qPhase_ff == `CCX_Q4 &&
            doWrite_ff && !resultToW_ff) begin
            dataMem[opAddr_ff] <= result_ff;
        end else if (swWrite && paddr == `CCX_ADDR_DDATA) begin
            dataMem[swAddr_ff] <= pwdata[7:0];
        end
    end

endmodule
`default_nettype wire

// [verilog/ccx_regs.vh]
/*
 * Register map, field positions, reset values, opcode patterns and timing
 * constants of the clear, complement and compare execution block.
 * Assumes it is included by bare name from the design files of this block.
 */
`ifndef CCX_REGS_VH
`define CCX_REGS_VH

// ****************************************************************
// APB register byte addresses
// ****************************************************************
`define CCX_ADDR_CTRL      12'h000
`define CCX_ADDR_BANK      12'h004
`define CCX_ADDR_WREG      12'h008
`define CCX_ADDR_STATUS    12'h00c
`define CCX_ADDR_INSTR     12'h010
`define CCX_ADDR_DADDR     12'h014
`define CCX_ADDR_DDATA     12'h018
`define CCX_ADDR_IDXBASE   12'h01c
`define CCX_ADDR_CYCLES    12'h020
`define CCX_ADDR_WDTCNT    12'h024

// ****************************************************************
// Field positions
// ****************************************************************
`define CCX_CTRL_EXT       0
`define CCX_ST_ZERO        0
`define CCX_ST_NEG         1
`define CCX_ST_PD_N        2
`define CCX_ST_TO_N        3
`define CCX_ST_BUSY        4
`define CCX_ST_SKIP        5
`define CCX_ST_ILLEGAL     6
`define CCX_INSTR_TWOWORD  16

// ****************************************************************
// Reset values
// ****************************************************************
`define CCX_RST_BANK       4'h0
`define CCX_RST_WREG       8'h00
`define CCX_RST_ZERO       1'b0
`define CCX_RST_NEG        1'b0
`define CCX_RST_PD_N       1'b1
`define CCX_RST_TO_N       1'b1
`define CCX_RST_IDXBASE    12'h000

// ****************************************************************
// Opcode patterns
// ****************************************************************
`define CCX_OP_CLR_HI      7'h35
`define CCX_OP_COMPLEMENT_REGISTER_OP_HI     6'h07
`define CCX_OP_CPEQ_HI     7'h31
`define CCX_OP_WDTCLR      16'h0004
`define CCX_CLEAR_VALUE    8'h00

// ****************************************************************
// Addressing constants
// ****************************************************************
`define CCX_ACCESS_SPLIT   8'h60
`define CCX_IDX_LIMIT      8'h5f
`define CCX_ACCESS_HI_BANK 4'hf
`define CCX_ACCESS_LO_BANK 4'h0

// ****************************************************************
// Quarter-cycle phases and cycle counts
// ****************************************************************
`define CCX_Q1             2'h0
`define CCX_Q2             2'h1
`define CCX_Q3             2'h2
`define CCX_Q4             2'h3
`define CCX_CYC_ONE        2'h1

`endif
